// ### rtc_ctrl_assertions.sv
module rtc_ctrl_checker #(
   parameter int WP_HOLD_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ad_oe_n,
   input wire logic chip_sel_n,
   input wire logic data_strobe,
   input wire logic read_not_write,
   input wire logic power_fail,
   input wire logic wave_out,
   input wire logic irq_n_out,
   input wire logic irq_n_oe_n,
   input wire logic write_protect,
   input wire logic clock_copy,
   input wire logic second_tick,
   input wire logic osc_on,
   input wire logic divider_run
);
   logic [15:0] low_cnt;

   // Cycles since power_fail dropped, saturating so it never wraps
   always_ff @(posedge ref_clk) begin
      if (!rst_n || power_fail) begin
         low_cnt <= 16'h0000;
      end else if (low_cnt != 16'hffff) begin
         low_cnt <= low_cnt + 16'h0001;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // ****************************************
   // Properties
   // ****************************************
   a_wp_on_fail: assert property (power_fail [*8] |-> write_protect)
      else $error("write protect missing during power fail");
   a_wp_hold_min: assert property ($fell(write_protect) |-> low_cnt >= WP_HOLD_CYCLES)
      else $error("write protect dropped early");
   a_wp_hold_max: assert property (write_protect && !power_fail |-> low_cnt <= WP_HOLD_CYCLES + 12)
      else $error("write protect held too long");
   a_bus_drive_read: assert property ($fell(ad_oe_n) |-> data_strobe && read_not_write && !chip_sel_n)
      else $error("bus driven outside a read");
   a_bus_release: assert property (!data_strobe [*8] |-> ad_oe_n)
      else $error("bus not released after strobe");
   a_run_stable: assert property (!data_strobe [*8] |-> $stable(osc_on) && $stable(divider_run))
      else $error("run state moved without a write");
   a_divider_needs_osc: assert property (divider_run |-> osc_on)
      else $error("divider running with oscillator off");
   a_tick_one_cycle: assert property (second_tick |=> !second_tick)
      else $error("update end pulse too long");
   a_copy_at_tick: assert property (clock_copy |-> second_tick)
      else $error("copy outside update end");
   a_irq_pull_low: assert property (!irq_n_oe_n |-> !irq_n_out)
      else $error("interrupt pin not pulled low");

   c_irq_on: cover property ($fell(irq_n_oe_n));
   c_irq_off: cover property ($rose(irq_n_oe_n));
   c_wp_end: cover property ($fell(write_protect));
   c_div_on: cover property ($rose(divider_run));
   c_wave: cover property ($changed(wave_out));
endmodule

bind rtc_ctrl_regs rtc_ctrl_checker #(.WP_HOLD_CYCLES(WP_HOLD_CYCLES)) chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .ad_oe_n(ad_oe_n), .chip_sel_n(chip_sel_n),
   .data_strobe(data_strobe), .read_not_write(read_not_write), .power_fail(power_fail),
   .wave_out(wave_out), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n),
   .write_protect(write_protect), .clock_copy(clock_copy), .second_tick(second_tick),
   .osc_on(osc_on), .divider_run(divider_run)
);

// ### rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] CTRL_A_OFS = 8'h0a;
   localparam logic [7:0] CTRL_B_OFS = 8'h0b;
   localparam logic [7:0] EVT_C_OFS  = 8'h0c;
   localparam logic [7:0] INTEG_D_OFS = 8'h0d;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int PEND_BIT    = 7;
   localparam int RUN_LSB     = 4;
   localparam int HOLD_BIT    = 7;
   localparam int PER_EN_BIT  = 6;
   localparam int ALM_EN_BIT  = 5;
   localparam int UPD_EN_BIT  = 4;
   localparam int WAVE_BIT    = 3;
   localparam int NUMFMT_BIT  = 2;
   localparam int HOUR_BIT    = 1;
   localparam int SUMMER_BIT  = 0;
   localparam int IRQF_BIT    = 7;
   localparam int PER_FLG_BIT = 6;
   localparam int ALM_FLG_BIT = 5;
   localparam int UPD_FLG_BIT = 4;
   localparam int KHZ_BIT     = 2;
   localparam int VALID_BIT   = 7;

   // ****************************************
   // Codes and reset values
   // ****************************************
   localparam logic [2:0] RUN_NORMAL = 3'h2;
   localparam logic [2:0] RUN_KHZ    = 3'h3;
   localparam logic [1:0] RUN_HOLD   = 2'h3;
   localparam logic [2:0] RUN_RST    = 3'h0;
   localparam logic [3:0] RATE_RST   = 4'h0;
   localparam logic [7:0] CTRL_B_RST = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int REF_CLK_HZ      = 40_000_000;
   localparam int HALF_TICK_HZ    = 65536;
   localparam int FIRST_UPDATE_MS = 500;
   // Multiply first so the half-tick count is not truncated
   localparam int FIRST_UPDATE_HT = HALF_TICK_HZ * FIRST_UPDATE_MS / 1000;
   localparam logic [15:0] DIV_START = 16'(65536 - FIRST_UPDATE_HT);
   localparam int PEND_LEAD_US    = 244;
   localparam int PEND_LEAD_HT    = HALF_TICK_HZ * PEND_LEAD_US / 1_000_000;
   localparam logic [15:0] PEND_POINT = 16'(65536 - PEND_LEAD_HT);
   localparam int WP_HOLD_MS      = 200;
   localparam int WP_HOLD_CYC     = REF_CLK_HZ / 1000 * WP_HOLD_MS;
   localparam int PIN_COUNT       = 14;
endpackage

// ### rtc_ctrl_regs.sv
module rtc_ctrl_regs #(
   parameter int WP_HOLD_CYCLES = rtc_ctrl_pkg::WP_HOLD_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] ad_in,
   output logic [7:0]      ad_out,
   output logic            ad_oe_n,
   input  wire logic       chip_sel_n,
   input  wire logic       addr_strobe,
   input  wire logic       data_strobe,
   input  wire logic       read_not_write,
   input  wire logic       power_fail,
   input  wire logic       backup_ok,
   input  wire logic       alarm_event,
   output logic            wave_out,
   output logic            irq_n_out,
   output logic            irq_n_oe_n,
   output logic            write_protect,
   output logic            clock_copy,
   output logic            second_tick,
   output logic            osc_on,
   output logic            divider_run,
   output logic            number_format,
   output logic            hour_mode,
   output logic            summer_time_en
);
   import rtc_ctrl_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] s1_reg;
   logic [PIN_COUNT-1:0] s2_reg;
   logic [PIN_COUNT-1:0] s3_reg;
   logic [PIN_COUNT-1:0] pin_reg;
   logic [PIN_COUNT-1:0] pin_d_reg;

   assign pin_raw = {ad_in, chip_sel_n, addr_strobe, data_strobe,
                     read_not_write, power_fail, backup_ok};

   // Three stages; second and third must agree before a change counts
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         s3_reg    <= '0;
         pin_d_reg <= '0;
      end else begin
         s1_reg    <= pin_raw;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         pin_d_reg <= pin_reg;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_agree
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               pin_reg[gi] <= 1'b0;
            end else if (s2_reg[gi] == s3_reg[gi]) begin
               pin_reg[gi] <= s3_reg[gi];
            end
         end
      end
   endgenerate

   logic [7:0] ad_s;
   logic       sel;
   logic       as_fall;
   logic       ds_fall;
   logic       ds_high;
   logic       rw_s;
   logic       pfail_s;
   logic       bok_s;

   assign ad_s    = pin_reg[13:6];
   assign sel     = ~pin_reg[5];
   assign as_fall = pin_d_reg[4] & ~pin_reg[4];
   assign ds_high = pin_reg[3];
   assign ds_fall = pin_d_reg[3] & ~pin_reg[3];
   assign rw_s    = pin_reg[2];
   assign pfail_s = pin_reg[1];
   assign bok_s   = pin_reg[0];

   // ****************************************
   // Bus decode
   // ****************************************
   logic [7:0] addr_reg;
   logic       wp_reg;
   logic       wr_evt;
   logic       rd_c;
   logic       hit;

   // Address latched on the falling address strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         addr_reg <= 8'h00;
      end else if (as_fall) begin
         addr_reg <= ad_s;
      end
   end

   assign hit = (addr_reg >= CTRL_A_OFS) && (addr_reg <= INTEG_D_OFS);
   assign wr_evt = ds_fall & ~rw_s & sel & ~wp_reg;
   // read completes on falling data strobe
   assign rd_c = ds_fall & rw_s & sel & (addr_reg == EVT_C_OFS);

   // ****************************************
   // Write protection
   // ****************************************
   logic [31:0] wp_cnt_reg;

   // Hold protection after supply recovers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wp_cnt_reg <= 32'h0;
         wp_reg     <= 1'b0;
      end else if (pfail_s) begin
         wp_cnt_reg <= 32'(WP_HOLD_CYCLES);
         wp_reg     <= 1'b1;
      end else if (wp_cnt_reg != 32'h0) begin
         wp_cnt_reg <= wp_cnt_reg - 32'h1;
         wp_reg     <= 1'b1;
      end else begin
         wp_reg <= 1'b0;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   logic [2:0] run_reg;
   logic [3:0] rate_reg;
   logic [7:0] ctrl_b_reg;
   logic       khz_reg;
   logic       run_now;

   // writes taken regardless of update cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run_reg  <= RUN_RST;
         rate_reg <= RATE_RST;
      end else if (wr_evt && addr_reg == CTRL_A_OFS) begin
         run_reg  <= ad_s[RUN_LSB +: 3];
         rate_reg <= ad_s[3:0];
      end
   end

   // Transfer hold forces the update enable clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_b_reg <= CTRL_B_RST;
      end else if (wr_evt && addr_reg == CTRL_B_OFS) begin
         ctrl_b_reg <= ad_s;
         ctrl_b_reg[UPD_EN_BIT] <= ad_s[UPD_EN_BIT] & ~ad_s[HOLD_BIT];
      end else if (ctrl_b_reg[HOLD_BIT]) begin
         ctrl_b_reg[UPD_EN_BIT] <= 1'b0;
      end
   end

   // Only code 011 opens the event register for writing
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         khz_reg <= 1'b0;
      end else if (wr_evt && addr_reg == CTRL_A_OFS
                   && ad_s[RUN_LSB +: 3] != RUN_KHZ) begin
         khz_reg <= 1'b0;
      end else if (wr_evt && addr_reg == EVT_C_OFS && run_reg == RUN_KHZ) begin
         khz_reg <= ad_s[KHZ_BIT];
      end
   end

   // ****************************************
   // Time base and divider
   // ****************************************
   logic [25:0] phase_reg;
   logic [26:0] phase_sum;
   logic        half_tick;
   logic [15:0] div_reg;
   logic        wrap;

   // Fractional accumulator: 65.536 kHz enable from 40 MHz
   assign phase_sum = {1'b0, phase_reg} + 27'(HALF_TICK_HZ);
   assign half_tick = phase_sum >= 27'(REF_CLK_HZ);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase_reg <= 26'h0;
      end else if (half_tick) begin
         phase_reg <= 26'(phase_sum - 27'(REF_CLK_HZ));
      end else begin
         phase_reg <= phase_sum[25:0];
      end
   end

   // 010 and 011 run the divider
   assign run_now = (run_reg == RUN_NORMAL) || (run_reg == RUN_KHZ);
   assign wrap = run_now & half_tick & (div_reg == 16'hffff);

   // Divider parked halfway so the first second takes 500 ms
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         div_reg <= DIV_START;
      end else if (!run_now) begin
         div_reg <= DIV_START;
      end else if (half_tick) begin
         div_reg <= div_reg + 16'h1;
      end
   end

   // ****************************************
   // Update cycle
   // ****************************************
   logic pend_reg;

   // Pending raised a little before the second boundary
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pend_reg <= 1'b0;
      end else if (ctrl_b_reg[HOLD_BIT] || wrap || !run_now) begin
         pend_reg <= 1'b0;
      end else if (half_tick && div_reg == PEND_POINT - 16'h1) begin
         pend_reg <= 1'b1;
      end
   end

   // Copy strobe to the time buffer, suppressed by hold
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         clock_copy  <= 1'b0;
         second_tick <= 1'b0;
      end else begin
         clock_copy  <= wrap & ~ctrl_b_reg[HOLD_BIT];
         second_tick <= wrap;
      end
   end

   // ****************************************
   // Rate select and wave output
   // ****************************************
   logic [3:0] rate_idx;
   logic       rate_lvl;
   logic       rate_d_reg;

   // codes 1 and 2 alias the 256 and 128 Hz taps
   always_comb begin
      rate_idx = rate_reg - 4'h1;
      if (rate_reg == 4'h1) begin
         rate_idx = 4'h7;
      end else if (rate_reg == 4'h2) begin
         rate_idx = 4'h8;
      end
   end

   assign rate_lvl = (rate_reg != 4'h0) & div_reg[rate_idx];

   // Output held low when disabled
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wave_out <= 1'b0;
      end else if (!ctrl_b_reg[WAVE_BIT]) begin
         wave_out <= 1'b0;
      end else if (khz_reg) begin
         wave_out <= div_reg[0];
      end else begin
         wave_out <= rate_lvl;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rate_d_reg <= 1'b0;
      end else begin
         rate_d_reg <= rate_lvl;
      end
   end

   // ****************************************
   // Event flags
   // ****************************************
   logic       upd_flag_reg;
   logic       alm_flag_reg;
   logic       per_flag_reg;
   logic       irqf_reg;
   logic       upd_flag_next;
   logic       alm_flag_next;
   logic       per_flag_next;
   logic       irqf_next;

   // Set beats the read clear so no event is lost
   always_comb begin
      upd_flag_next = (upd_flag_reg & ~rd_c) | wrap;
      alm_flag_next = (alm_flag_reg & ~rd_c) | alarm_event;
      per_flag_next = (per_flag_reg & ~rd_c) | (rate_lvl & ~rate_d_reg);
      irqf_next = (irqf_reg & ~rd_c)
                | (per_flag_next & ctrl_b_reg[PER_EN_BIT])
                | (alm_flag_next & ctrl_b_reg[ALM_EN_BIT])
                | (upd_flag_next & ctrl_b_reg[UPD_EN_BIT]);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         upd_flag_reg <= 1'b0;
         alm_flag_reg <= 1'b0;
         per_flag_reg <= 1'b0;
         irqf_reg     <= 1'b0;
      end else begin
         upd_flag_reg <= upd_flag_next;
         alm_flag_reg <= alm_flag_next;
         per_flag_reg <= per_flag_next;
         irqf_reg     <= irqf_next;
      end
   end

   // Open-drain request line, pulled low only
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_n_out  <= 1'b0;
         irq_n_oe_n <= 1'b1;
      end else begin
         irq_n_out <= 1'b0;
         irq_n_oe_n <= ~irqf_next;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   logic [7:0] rd_data;
   logic       bvalid_reg;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
      end else begin
         bvalid_reg <= bok_s;
      end
   end

   always_comb begin
      unique case (addr_reg)
         CTRL_A_OFS:  rd_data = {pend_reg, run_reg, rate_reg};
         CTRL_B_OFS:  rd_data = ctrl_b_reg;
         EVT_C_OFS:   rd_data = {irqf_reg, per_flag_reg, alm_flag_reg, upd_flag_reg,
                                 1'b0, khz_reg, 2'b00};
         INTEG_D_OFS: rd_data = {bvalid_reg, 7'h00};
         default:     rd_data = 8'h00;
      endcase
   end

   // Bus driven only for mapped offsets during a read strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ad_out  <= 8'h00;
         ad_oe_n <= 1'b1;
      end else begin
         ad_out  <= rd_data;
         ad_oe_n <= ~(sel & rw_s & ds_high & hit);
      end
   end

   // ****************************************
   // Status and configuration outputs
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         write_protect  <= 1'b0;
         osc_on         <= 1'b0;
         divider_run    <= 1'b0;
         number_format  <= 1'b0;
         hour_mode      <= 1'b0;
         summer_time_en <= 1'b0;
      end else begin
         write_protect <= wp_reg;
         osc_on      <= run_now | (run_reg[2:1] == RUN_HOLD);
         divider_run <= run_now;
         number_format <= ctrl_b_reg[NUMFMT_BIT];
         hour_mode <= ctrl_b_reg[HOUR_BIT];
         summer_time_en <= ctrl_b_reg[SUMMER_BIT];
      end
   end
endmodule

// ### rtc_host_model.sv
module rtc_host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] ad_out,
   input  wire logic       ad_oe_n,
   output logic      [7:0] ad_in,
   output logic            chip_sel_n,
   output logic            addr_strobe,
   output logic            data_strobe,
   output logic            read_not_write
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] drv_val;
   logic       drv_on;

   // Released bus shows the inverse of the last value, never a stale copy
   assign ad_in = !ad_oe_n ? ad_out : (drv_on ? drv_val : ~drv_val);

   initial begin
      drv_val        = 8'h00;
      drv_on         = 1'b0;
      chip_sel_n     = 1'b1;
      addr_strobe    = 1'b0;
      data_strobe    = 1'b0;
      read_not_write = 1'b1;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // One bus cycle; address phases and write strobe held 6 cycles, release 8, for the pin synchronisers
   task automatic cycle(input logic [7:0] adr, input logic rd, input logic [7:0] wdat,
                        output logic [7:0] rdat, output logic seen);
      int k;
      @(posedge ref_clk);
      chip_sel_n  <= 1'b0;
      drv_on      <= 1'b1;
      drv_val     <= adr;
      addr_strobe <= 1'b1;
      step(6);
      addr_strobe <= 1'b0;
      step(6);
      read_not_write <= rd;
      drv_on         <= !rd;
      drv_val        <= wdat;
      data_strobe    <= 1'b1;
      seen = 1'b0;
      rdat = 8'h00;
      k = 0;
      // Strobe held until the answer is taken or the wait runs out
      while (rd && !seen && k < 16) begin
         step(1);
         k++;
         seen = !ad_oe_n;
         rdat = ad_out;
      end
      if (!rd) begin
         step(6);
      end
      data_strobe <= 1'b0;
      step(8);
      chip_sel_n     <= 1'b1;
      read_not_write <= 1'b1;
      drv_on         <= 1'b0;
   endtask
endmodule

// ### tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_ctrl_pkg::*;
   logic       ref_clk, rst_n, power_fail, backup_ok, alarm_event;
   logic [7:0] ad_in, ad_out;
   logic       ad_oe_n, chip_sel_n, addr_strobe, data_strobe, read_not_write;
   logic       wave_out, irq_n_out, irq_n_oe_n, write_protect;
   logic       number_format, hour_mode, summer_time_en;
   logic       clock_copy, second_tick, osc_on, divider_run;
   int         miscompares = 0;
   int         comparisons = 0;
   int         cyc = 0;

   rtc_ctrl_regs #(.WP_HOLD_CYCLES(20)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .ad_in(ad_in), .ad_out(ad_out),
      .ad_oe_n(ad_oe_n), .chip_sel_n(chip_sel_n), .addr_strobe(addr_strobe),
      .data_strobe(data_strobe), .read_not_write(read_not_write),
      .power_fail(power_fail), .backup_ok(backup_ok), .alarm_event(alarm_event),
      .wave_out(wave_out), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n),
      .write_protect(write_protect), .clock_copy(clock_copy),
      .second_tick(second_tick), .osc_on(osc_on),
      .divider_run(divider_run), .number_format(number_format), .hour_mode(hour_mode),
      .summer_time_en(summer_time_en));

   rtc_host_model host (
      .ref_clk(ref_clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in),
      .chip_sel_n(chip_sel_n), .addr_strobe(addr_strobe), .data_strobe(data_strobe),
      .read_not_write(read_not_write));

   // Clock and free cycle count for interval checks
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;

   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      logic       s;
      host.cycle(a, 1'b0, d, x, s);
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] x;
      logic       s;
      host.cycle(a, 1'b1, 8'h00, x, s);
      check(n, {7'h00, s, x}, {8'h01, e});
   endtask
   task automatic wait_irq(input logic lvl);
      int k;
      k = 0;
      while (irq_n_oe_n !== lvl && k < 6000) begin
         @(posedge ref_clk);
         k++;
      end
   endtask
   // Cycles between two successive edges of wave_out, bounded
   task automatic wave_gap(output int n);
      logic w;
      @(posedge ref_clk);
      for (int i = 0; i < 2; i++) begin
         w = wave_out;
         n = 0;
         while (wave_out === w && n < 6000) begin
            @(posedge ref_clk);
            n++;
         end
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      logic [7:0] x;
      logic       s;
      rdchk("ctrl a", CTRL_A_OFS, 8'h00);
      rdchk("ctrl b", CTRL_B_OFS, 8'h00);
      rdchk("event", EVT_C_OFS, 8'h00);
      rdchk("integrity", INTEG_D_OFS, 8'h80);
      backup_ok <= 1'b0;
      host.step(8);
      rdchk("integrity low", INTEG_D_OFS, 8'h00);
      backup_ok <= 1'b1;
      host.cycle(8'h05, 1'b1, 8'h00, x, s);
      check("unmapped drive", 16'(s), 16'h0);
      $display("test reset done");
   endtask
   task automatic t_run;
      logic [1:0] e;
      for (int c = 0; c < 8; c++) begin
         wr(CTRL_A_OFS, {1'b1, 3'(c), 4'hf});
         e = (c == 2 || c == 3) ? 2'b11 : (c >= 6 ? 2'b10 : 2'b00);
         rdchk("ctrl a run", CTRL_A_OFS, {1'b0, 3'(c), 4'hf});
         check("osc div", 16'({osc_on, divider_run}), 16'(e));
         check("no early update", 16'({clock_copy, second_tick}), 16'h0);
      end
      $display("test run codes done");
   endtask
   task automatic t_regb;
      wr(CTRL_B_OFS, 8'h07);
      rdchk("ctrl b", CTRL_B_OFS, 8'h07);
      check("formats", 16'({number_format, hour_mode, summer_time_en}), 16'h7);
      wr(CTRL_B_OFS, 8'h02);
      check("formats", 16'({number_format, hour_mode, summer_time_en}), 16'h2);
      wr(CTRL_B_OFS, 8'h90);
      rdchk("hold clears uie", CTRL_B_OFS, 8'h80);
      wr(CTRL_B_OFS, 8'h00);
      $display("test control b done");
   endtask
   task automatic t_khz;
      int n;
      wr(CTRL_A_OFS, 8'h30);
      wr(EVT_C_OFS, 8'hff);
      rdchk("khz set", EVT_C_OFS, 8'h04);
      wr(CTRL_B_OFS, 8'h08);
      wave_gap(n);
      check("khz half period", 16'(n >= 609 && n <= 612), 16'h1);
      wr(CTRL_A_OFS, 8'h20);
      rdchk("khz cleared", EVT_C_OFS, 8'h00);
      wr(EVT_C_OFS, 8'h04);
      rdchk("khz refused", EVT_C_OFS, 8'h00);
      wr(CTRL_B_OFS, 8'h00);
      host.step(4);
      check("wave held low", 16'(wave_out), 16'h0);
      $display("test khz done");
   endtask
   task automatic t_periodic;
      int n;
      int t0;
      wr(CTRL_A_OFS, 8'h23);
      wr(CTRL_B_OFS, 8'h48);
      wave_gap(n);
      check("rate half period", 16'(n >= 2439 && n <= 2444), 16'h1);
      rdchk("periodic flag", EVT_C_OFS, 8'hc0);
      wait_irq(1'b0);
      t0 = cyc;
      rdchk("periodic again", EVT_C_OFS, 8'hc0);
      check("irq released", 16'(irq_n_oe_n), 16'h1);
      wait_irq(1'b0);
      check("periodic interval", 16'(cyc - t0 >= 4880 && cyc - t0 <= 4886), 16'h1);
      check("irq low", 16'(irq_n_oe_n), 16'h0);
      wr(CTRL_A_OFS, 8'h20);
      wr(CTRL_B_OFS, 8'h00);
      rdchk("flags left", EVT_C_OFS, 8'hc0);
      $display("test periodic done");
   endtask
   task automatic t_alarm;
      for (int i = 0; i < 2; i++) begin
         wr(CTRL_B_OFS, i == 0 ? 8'h20 : 8'h00);
         @(posedge ref_clk);
         alarm_event <= 1'b1;
         @(posedge ref_clk);
         alarm_event <= 1'b0;
         host.step(3);
         check("irq on alarm", 16'(irq_n_oe_n), 16'(i));
         rdchk("alarm flag", EVT_C_OFS, i == 0 ? 8'ha0 : 8'h20);
         check("irq after read", 16'(irq_n_oe_n), 16'h1);
      end
      $display("test alarm done");
   endtask
   task automatic t_wp;
      int k;
      wr(CTRL_B_OFS, 8'h02);
      power_fail <= 1'b1;
      host.step(10);
      check("protect on", 16'(write_protect), 16'h1);
      wr(CTRL_B_OFS, 8'h05);
      rdchk("write ignored", CTRL_B_OFS, 8'h02);
      power_fail <= 1'b0;
      host.step(10);
      check("protect held", 16'(write_protect), 16'h1);
      k = 0;
      while (write_protect !== 1'b0 && k < 60) begin
         @(posedge ref_clk);
         k++;
      end
      check("protect end", 16'(k < 60), 16'h1);
      wr(CTRL_B_OFS, 8'h05);
      rdchk("write taken", CTRL_B_OFS, 8'h05);
      $display("test protect done");
   endtask

   task automatic conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the expected run of about 15k cycles
   initial begin
      repeat (90000) @(posedge ref_clk);
      miscompares++;
      conclude();
   end

   initial begin
      rst_n       = 1'b0;
      power_fail  = 1'b0;
      backup_ok   = 1'b1;
      alarm_event = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      t_reset();
      t_run();
      t_regb();
      t_khz();
      t_periodic();
      t_alarm();
      t_wp();
      conclude();
   end
endmodule
